// >>> design/hsl_energy.sv
/*
  Power product and energy accumulator. Assumes the converter pair
  presents current and paired voltage together with a one-cycle valid.
*/
`timescale 1ns/10ps
`default_nettype none
module hsl_energy #(
  parameter int DW    = 16,
  parameter int ACC_W = 48
) (
  input  wire logic              ref_clk,
  input  wire logic              rstn,
  input  wire logic              sample_valid,
  input  wire logic [DW-1:0]     cur,
  input  wire logic [DW-1:0]     volt,
  input  wire logic              clear,
  output logic      [2*DW-1:0]   power,
  output logic      [ACC_W-1:0]  acc,
  output logic                   ovf
);
  logic [2*DW-1:0]  prod;
  logic [ACC_W:0]   sum;

  assign prod = cur * volt;
  assign sum  = {1'b0, acc} + {{(ACC_W+1-2*DW){1'b0}}, prod};

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      power <= '0;
      acc   <= '0;
      ovf   <= 1'b0;
    end else begin
      ovf <= 1'b0;
      if (clear) begin
        acc <= '0;
      end else if (sample_valid) begin
        power <= prod;
        acc   <= sum[ACC_W-1:0];
        ovf   <= sum[ACC_W];
      end
    end
  end
endmodule
`default_nettype wire

// >>> design/hsl_sync.sv
/*
  Two-flop synchroniser for a bus of independent level flags.
  Assumes every bit is a slow level; no bit relation is preserved.
*/
`timescale 1ns/10ps
`default_nettype none
module hsl_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule
`default_nettype wire

// >>> design/hsl_top.sv
/*
  Hot swap supervisor control logic: startup debounce, gate command,
  fault handling, power-good sequencing, general pins, converter control
  and energy accumulation, with a plain register port.
  Assumes comparator flags are levels from analog cores, converter data
  arrive with a one-cycle valid, and general pins are open drain.
*/
`timescale 1ns/10ps
`default_nettype none
module hsl_top #(
  parameter int TICK_CYCLES = hsl_pkg::TICK_CYC,
  parameter int PGI_TMO_MS  = hsl_pkg::PGI_TMO_MS_DEF,
  parameter int ACC_W       = 48
) (
  input  wire logic                   ref_clk,
  input  wire logic                   rstn,
  input  wire logic [hsl_pkg::AW-1:0] reg_addr,
  input  wire logic [hsl_pkg::DW-1:0] reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [hsl_pkg::DW-1:0] reg_rdata,
  input  wire logic                   vin_uvlo_ok,
  input  wire logic                   internal_logic_supply_ok,
  input  wire logic                   undervolt_upper_input,
  input  wire logic                   undervolt_lower_input,
  input  wire logic                   undervolt_lower_reset,
  input  wire logic                   overvolt_input,
  input  wire logic                   enable_n,
  input  wire logic                   output_low_threshold,
  input  wire logic                   drain_low,
  input  wire logic                   gate_high,
  input  wire logic                   short_trip,
  input  wire logic                   thermal_timer_node,
  input  wire logic                   fet_bad_flag,
  input  wire logic                   fet_short_flag,
  input  wire logic                   write_protect,
  input  wire logic [3:0]             general_pin_in,
  output logic      [3:0]             general_pin_out,
  output logic      [3:0]             general_pin_oe,
  input  wire logic                   conv_valid,
  input  wire logic [hsl_pkg::DW-1:0] current_converter,
  input  wire logic [hsl_pkg::DW-1:0] voltage_converter,
  output logic                        gate_on,
  output logic                        fast_pulldown,
  output logic                        ramp_inrush,
  output logic      [3:0]             ilim_code,
  output logic      [1:0]             foldback_code,
  output logic                        foldback_on,
  output logic      [2:0]             conv_res,
  output logic      [3:0]             aux_sel,
  output logic                        volt_src_drain,
  output logic                        energy_alert,
  output logic                        nvm_write,
  output logic                        nvm_fault_log
);
  import hsl_pkg::*;

  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
  localparam logic [15:0]   WD_TICKS  = 16'(PGI_TMO_MS / TICK_MS);

  function automatic logic hit(input logic [AW-1:0] a, input logic [AW-1:0] o);
    return a == o;
  endfunction

  function automatic logic [3:0] clamp4(input logic [3:0] v, input logic [3:0] mx);
    return (v > mx) ? mx : v;
  endfunction

  // Flag capture
  logic [NIN-1:0] raw;
  logic [NIN-1:0] s;

  assign raw = {general_pin_in, write_protect, fet_short_flag, fet_bad_flag,
                thermal_timer_node, short_trip, gate_high, drain_low,
                output_low_threshold, enable_n, overvolt_input,
                undervolt_lower_reset, undervolt_lower_input,
                undervolt_upper_input, internal_logic_supply_ok, vin_uvlo_ok};

  hsl_sync #(.W(NIN)) u_sync (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .d       (raw),
    .q       (s)
  );

  wire       vin_ok   = s[IN_VIN];
  wire       vcc_ok   = s[IN_VCC];
  wire       uvh_up   = s[IN_UVH];
  wire       uvl_up   = s[IN_UVL];
  wire       uv_rst   = s[IN_UVRST];
  wire       ov_trip  = s[IN_OV];
  wire       en_n_s   = s[IN_ENN];
  wire       vout_up  = s[IN_VOUT];
  wire       drn_low  = s[IN_DRN];
  wire       gate_hi  = s[IN_GATE];
  wire       sc_trip  = s[IN_SC];
  wire       tmr_trip = s[IN_TMR];
  wire       fbad     = s[IN_FBAD];
  wire       fshort   = s[IN_FSHORT];
  wire       wp       = s[IN_WP];
  wire [3:0] gp_s     = s[IN_GP +: 4];

  // Registers
  logic [DW-1:0]  ctrl_r;
  logic [3:0]     ilim_r;
  logic [1:0]     fold_r;
  logic [2:0]     res_r;
  logic [3:0]     aux_r;
  logic [7:0]     rt_dly_r;
  logic [3:0]     rt_cnt_r;
  logic [7:0]     gpcfg_r;
  logic [NF-1:0]  fault_r;
  logic [DW-1:0]  rdata_r;

  wire wr_ctrl  = reg_wr & hit(reg_addr, REG_CTRL);
  wire wr_ilim  = reg_wr & hit(reg_addr, REG_ILIM);
  wire wr_fold  = reg_wr & hit(reg_addr, REG_FOLD);
  wire wr_adc   = reg_wr & hit(reg_addr, REG_ADC);
  wire wr_retry = reg_wr & hit(reg_addr, REG_RETRY);
  wire wr_gpcfg = reg_wr & hit(reg_addr, REG_GPCFG);
  wire wr_fault = reg_wr & hit(reg_addr, REG_FAULT);
  wire wr_nvm   = reg_wr & hit(reg_addr, REG_NVM);
  wire wr_eclr  = reg_wr & hit(reg_addr, REG_ENE_LO);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r   <= CTRL_RST;
      ilim_r   <= ILIM_RST;
      fold_r   <= FOLD_RST;
      res_r    <= '0;
      aux_r    <= '0;
      rt_dly_r <= RT_DLY_RST;
      rt_cnt_r <= RT_CNT_RST;
      gpcfg_r  <= GPCFG_RST;
    end else begin
      if (wr_ctrl)  ctrl_r   <= reg_wdata;
      if (wr_ilim)  ilim_r   <= reg_wdata[3:0];
      if (wr_fold)  fold_r   <= reg_wdata[1:0];
      if (wr_adc) begin
        res_r <= 3'(clamp4({1'b0, reg_wdata[2:0]}, {1'b0, RES_MAX}));
        aux_r <= clamp4(reg_wdata[6:3], AUX_MAX);
      end
      if (wr_retry) begin
        rt_dly_r <= reg_wdata[7:0];
        rt_cnt_r <= reg_wdata[11:8];
      end
      if (wr_gpcfg) gpcfg_r  <= reg_wdata[7:0];
    end
  end

  // Millisecond tick
  logic [TW-1:0] tick_cnt_r;
  logic          tick_r;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b0;
    end else begin
      tick_r     <= (tick_cnt_r == TICK_LAST);
      tick_cnt_r <= (tick_cnt_r == TICK_LAST) ? '0 : tick_cnt_r + 1'b1;
    end
  end

  // Undervolt hysteresis and fault-clear events
  logic uv_ok_r;
  logic en_d_r;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      uv_ok_r <= 1'b0;
      en_d_r  <= 1'b0;  // No false fall
    end else begin
      en_d_r <= en_n_s;
      if (uvh_up && uvl_up) begin
        uv_ok_r <= 1'b1;
      end else if (!uvh_up && !uvl_up) begin
        uv_ok_r <= 1'b0;
      end
    end
  end

  wire en_fall   = en_d_r & ~en_n_s;
  wire clr_evt   = en_fall | uv_rst;

  // General pin functions
  wire pin3_func = gpcfg_r[5:4] == GP_FUNC;
  wire pin4_func = gpcfg_r[7:6] == GP_FUNC;
  wire ext_act   = pin4_func & (ctrl_r[CT_EXTINV] ? gp_s[3] : ~gp_s[3]);
  wire pgi_good  = ctrl_r[CT_PGIINV] ? ~gp_s[2] : gp_s[2];

  // Sequencer
  hsl_state_e state_r;
  hsl_state_e state_nxt;
  logic [7:0] tcnt_r;
  logic [3:0] retry_left_r;
  logic       latch_r;
  logic       pg1_r;
  logic       pg2_r;
  logic       wd_exp;

  wire on_st    = state_r == ST_ON;
  wire oc_trip  = tmr_trip | sc_trip;
  wire retry_ok = ctrl_r[CT_RETRY] & ((retry_left_r != '0) | (rt_cnt_r == RT_INF));

  // Every startup condition, also kept while on
  wire start_ok = vin_ok & vcc_ok & uv_ok_r & ~ov_trip & ~en_n_s & ~ext_act
                & ~latch_r & ctrl_r[CT_ON] & ~oc_trip & ~fbad & ~fshort;

  wire gate_trip = on_st & (~start_ok | wd_exp);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_WAIT: if (start_ok) state_nxt = ST_DEB;
      ST_DEB: begin
        if (!start_ok) begin
          state_nxt = ST_WAIT;
        end else if (tick_r && tcnt_r == DEB_TICKS - 8'h01) begin
          state_nxt = ST_ON;
        end
      end
      ST_ON: begin
        if (gate_trip) begin
          state_nxt = (oc_trip && retry_ok) ? ST_COOL : ST_WAIT;
        end
      end
      ST_COOL: begin
        if (clr_evt || (tick_r && tcnt_r >= rt_dly_r)) state_nxt = ST_WAIT;
      end
    endcase
  end

  // A latching fault keeps the gate off until a clear event
  wire latch_set = on_st & (fbad | fshort | ext_act | wd_exp | (oc_trip & ~retry_ok));

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_r      <= ST_WAIT;
      tcnt_r       <= '0;
      retry_left_r <= RT_CNT_RST;
      latch_r      <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (state_nxt != state_r) begin
        tcnt_r <= '0;
      end else if (tick_r && tcnt_r != 8'hff) begin
        tcnt_r <= tcnt_r + 8'h01;
      end
      if (wr_retry) begin
        retry_left_r <= reg_wdata[11:8];
      end else if (clr_evt) begin
        retry_left_r <= rt_cnt_r;
      end else if (state_nxt == ST_COOL && on_st && rt_cnt_r != RT_INF) begin
        retry_left_r <= retry_left_r - 4'h1;
      end
      // Set wins over clear
      latch_r <= latch_set | (latch_r & ~clr_evt);
    end
  end

  // Power good sequencing, independent of overvoltage
  logic [9:0] pg_cnt_r;
  wire        pg_cond = drn_low & vout_up & gate_hi;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pg_cnt_r <= '0;
      pg1_r    <= 1'b0;
      pg2_r    <= 1'b0;
    end else begin
      if (!pg_cond) begin
        pg_cnt_r <= '0;
      end else if (tick_r && pg_cnt_r < {PG_TICKS[8:0], 1'b0}) begin
        pg_cnt_r <= pg_cnt_r + 10'h001;
      end
      pg1_r <= pg_cond & (pg_cnt_r >= PG_TICKS);
      pg2_r <= pg_cond & (pg_cnt_r >= {PG_TICKS[8:0], 1'b0});
    end
  end

  // Watchdog: downstream good must arrive within the timeout
  logic [15:0] wd_cnt_r;
  logic        wd_seen_r;

  assign wd_exp = pin3_func & pg2_r & ~wd_seen_r & (wd_cnt_r >= WD_TICKS);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wd_cnt_r  <= '0;
      wd_seen_r <= 1'b0;
    end else if (!on_st || !pg2_r) begin
      wd_cnt_r  <= '0;
      wd_seen_r <= 1'b0;
    end else begin
      if (pgi_good) wd_seen_r <= 1'b1;
      if (tick_r && wd_cnt_r != 16'hffff) wd_cnt_r <= wd_cnt_r + 16'h0001;
    end
  end

  // Energy path
  logic [2*DW-1:0]  power;
  logic [ACC_W-1:0] acc;
  logic             acc_ovf;

  hsl_energy #(.DW(DW), .ACC_W(ACC_W)) u_energy (
    .ref_clk      (ref_clk),
    .rstn         (rstn),
    .sample_valid (conv_valid),
    .cur          (current_converter),
    .volt         (voltage_converter),
    .clear        (wr_eclr),
    .power        (power),
    .acc          (acc),
    .ovf          (acc_ovf)
  );

  // Fault log
  logic [NF-1:0] fset;
  logic [NF-1:0] fclr;

  always_comb begin
    fset         = '0;
    fset[F_OV]   = on_st & ov_trip;
    fset[F_UV]   = on_st & ~uv_ok_r;
    fset[F_OC]   = on_st & oc_trip;
    fset[F_FETBAD] = on_st & fbad;
    fset[F_PGI]  = wd_exp;
    fset[F_SHORT] = fshort;
    fset[F_EXT]  = ext_act;
    fset[F_EOVF] = acc_ovf & ctrl_r[CT_EALERT];
    fclr = clr_evt ? {NF{1'b1}} : (wr_fault ? reg_wdata[NF-1:0] : '0);
  end

  wire [NF-1:0] fnew = fset & ~fault_r;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fault_r <= '0;
    end else begin
      fault_r <= (fault_r & ~fclr) | fset;
    end
  end

  // Status word
  wire [DW-1:0] status = {3'h0, gp_s, pg2_r, pg1_r, gate_on, ~vout_up,
                          uv_ok_r, state_r, latch_r, wp};

  logic [DW-1:0] rd_mux;

  always_comb begin
    unique case (reg_addr)
      REG_CTRL:   rd_mux = ctrl_r;
      REG_ILIM:   rd_mux = {12'h000, ilim_r};
      REG_FOLD:   rd_mux = {14'h0000, fold_r};
      REG_ADC:    rd_mux = {9'h000, aux_r, res_r};
      REG_RETRY:  rd_mux = {4'h0, rt_cnt_r, rt_dly_r};
      REG_GPCFG:  rd_mux = {8'h00, gpcfg_r};
      REG_STATUS: rd_mux = status;
      REG_FAULT:  rd_mux = {8'h00, fault_r};
      REG_POWER:  rd_mux = power[2*DW-1:DW];
      REG_ENE_LO: rd_mux = acc[ACC_W-DW-1 -: DW];
      REG_ENE_HI: rd_mux = acc[ACC_W-1 -: DW];
      default:    rd_mux = '0;
    endcase
  end

  // Pin drive: open drain, power good released when good
  logic [3:0] oe_nxt;

  always_comb begin
    oe_nxt = '0;
    for (int i = 0; i < 4; i++) begin
      unique case (gpcfg_r[2*i +: 2])
        GP_FUNC: oe_nxt[i] = (i == 0) ? ~pg1_r : ((i == 1) ? ~pg2_r : 1'b0);
        GP_IN:   oe_nxt[i] = 1'b0;
        GP_LOW:  oe_nxt[i] = 1'b1;
        GP_REL:  oe_nxt[i] = 1'b0;
      endcase
    end
  end

  // Output flops
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r         <= '0;
      gate_on         <= 1'b0;
      fast_pulldown   <= 1'b0;
      foldback_on     <= 1'b0;
      energy_alert    <= 1'b0;
      nvm_write       <= 1'b0;
      nvm_fault_log   <= 1'b0;
      general_pin_oe  <= '0;
      general_pin_out <= '0;
    end else begin
      rdata_r        <= reg_rd ? rd_mux : '0;
      gate_on        <= state_nxt == ST_ON;
      fast_pulldown  <= sc_trip;
      foldback_on    <= on_st & ~vout_up & (fold_r != FOLD_NONE);
      energy_alert   <= fault_r[F_EOVF] | fset[F_EOVF];
      // Fault logging ignores write protect
      nvm_write      <= (wr_nvm & reg_wdata[NVM_SAVE] & ~wp) | (|fnew);
      nvm_fault_log  <= |fnew;
      general_pin_oe <= oe_nxt;
    end
  end

  assign reg_rdata      = rdata_r;
  assign ramp_inrush    = ctrl_r[CT_RAMP];
  assign volt_src_drain = ctrl_r[CT_ESRC];
  assign ilim_code      = ilim_r;
  assign foldback_code  = fold_r;
  assign conv_res       = res_r;
  assign aux_sel        = aux_r;
endmodule
`default_nettype wire

// >>> include/hsl_pkg.sv
/*
  Constants, register map, field layout and state encoding shared by the
  hot swap supervisor logic. Assumes a single 20 MHz logic clock.
*/
// Notes on behaviour
// - Turn on needs both undervoltage comparators above
// - Turn off only when both comparators below
// - Lower input below reset level clears faults
// - Supply lockout holds gate command low
// - Output below threshold sets output-low status
// - Write protect blocks all but fault-log writes
// - Gate stays off until every startup condition
// - Inrush method: current limit or ramp
// - Two power-good outputs, twice debounce each
// - Power good needs drain, output, gate flags
// - Pin three watchdog turns gate off
// - Pin four active-low external fault; pins configurable
// - Current limit setting 15mV to 30mV
// - Foldback 10, 20 or 50 percent when low
// - Short comparator fires fast pull-down immediately
// - Thermal timer trip logs overcurrent, gate off
// - Overcurrent latches off or retries, configurable
// - Log and respond to all other faults
// - Five converter resolution and rate settings
// - Current converter continuous, voltage converter paired
// - Power is product; energy accumulates power
// - Optional alert on energy accumulator overflow
// - Conditions hold 128ms, violation restarts debounce
// - Enable falling clears faults, high turns off
// - Overvoltage turns gate off, power good untouched
package hsl_pkg;
  localparam int CLK_HZ         = 20_000_000;
  localparam int TICK_MS        = 1;
  localparam int TICK_CYC       = CLK_HZ / 1000 * TICK_MS;
  localparam int DEBOUNCE_MS    = 128;
  localparam int PG_DELAY_MS    = 2 * DEBOUNCE_MS;
  localparam int PGI_TMO_MS_DEF = 200;

  localparam logic [7:0] DEB_TICKS = 8'(DEBOUNCE_MS / TICK_MS);
  localparam logic [9:0] PG_TICKS  = 10'(PG_DELAY_MS / TICK_MS);

  localparam int AW = 4;
  localparam int DW = 16;

  localparam logic [AW-1:0] REG_CTRL   = 4'h0;
  localparam logic [AW-1:0] REG_ILIM   = 4'h1;
  localparam logic [AW-1:0] REG_FOLD   = 4'h2;
  localparam logic [AW-1:0] REG_ADC    = 4'h3;
  localparam logic [AW-1:0] REG_RETRY  = 4'h4;
  localparam logic [AW-1:0] REG_GPCFG  = 4'h5;
  localparam logic [AW-1:0] REG_STATUS = 4'h6;
  localparam logic [AW-1:0] REG_FAULT  = 4'h7;
  localparam logic [AW-1:0] REG_POWER  = 4'h8;
  localparam logic [AW-1:0] REG_ENE_LO = 4'h9;
  localparam logic [AW-1:0] REG_ENE_HI = 4'ha;
  localparam logic [AW-1:0] REG_NVM    = 4'hb;

  localparam int CT_ON = 0, CT_RAMP = 1, CT_RETRY = 2, CT_EALERT = 3;
  localparam int CT_ESRC = 4, CT_EXTINV = 5, CT_PGIINV = 6;
  localparam logic [DW-1:0] CTRL_RST  = 16'h0001;
  localparam logic [3:0]    ILIM_RST  = 4'h5;
  localparam logic [1:0]    FOLD_RST  = 2'h1;
  localparam logic [1:0]    FOLD_NONE = 2'h3;
  localparam logic [2:0]    RES_MAX   = 3'h4;
  localparam logic [3:0]    AUX_MAX   = 4'hd;
  localparam logic [7:0]    RT_DLY_RST = 8'h64;
  localparam logic [3:0]    RT_CNT_RST = 4'h0;
  localparam logic [3:0]    RT_INF     = 4'hf;
  localparam logic [7:0]    GPCFG_RST  = 8'h00;
  localparam int NVM_SAVE = 0;

  localparam logic [1:0] GP_FUNC = 2'h0, GP_IN = 2'h1, GP_LOW = 2'h2, GP_REL = 2'h3;

  localparam int F_OV = 0, F_UV = 1, F_OC = 2, F_FETBAD = 3;
  localparam int F_PGI = 4, F_SHORT = 5, F_EXT = 6, F_EOVF = 7, NF = 8;

  localparam int IN_VIN = 0, IN_VCC = 1, IN_UVH = 2, IN_UVL = 3, IN_UVRST = 4;
  localparam int IN_OV = 5, IN_ENN = 6, IN_VOUT = 7, IN_DRN = 8, IN_GATE = 9;
  localparam int IN_SC = 10, IN_TMR = 11, IN_FBAD = 12, IN_FSHORT = 13;
  localparam int IN_WP = 14, IN_GP = 15, NIN = 19;

  typedef enum logic [1:0] {
    ST_WAIT = 2'b00,
    ST_DEB  = 2'b01,
    ST_ON   = 2'b10,
    ST_COOL = 2'b11
  } hsl_state_e;
endpackage

// >>> sim/hsl_partner.sv
/* Far side model: pass transistor flags, open-drain pins, converters.
   Assumes pins have pull-ups; gate charge and decay take RISE cycles. */
`timescale 1ns/10ps
`default_nettype none
module hsl_partner #(
  parameter int RISE = 6
) (
  input  wire logic        ref_clk,
  input  wire logic        gate_on,
  input  wire logic        ext_fault_n,
  input  wire logic [3:0]  general_pin_oe,
  output logic      [3:0]  general_pin_in,
  output logic             drain_low,
  output logic             gate_high,
  output logic             output_low_threshold,
  output logic             conv_valid,
  output logic      [15:0] current_converter,
  output logic      [15:0] voltage_converter
);
  int n = 0;
  int t = 0;
  always @(posedge ref_clk) begin
    n <= gate_on ? (n < RISE ? n + 1 : n) : (n > 0 ? n - 1 : 0);
    t <= (t + 1) % 16;
  end
  assign {drain_low, gate_high, output_low_threshold} = {3{n == RISE}};
  assign conv_valid = t == 15;
  // Data only meaningful with valid; garbage otherwise
  assign current_converter = conv_valid ? 16'h0100 : 16'hfeff;
  assign voltage_converter = conv_valid ? 16'h0200 : 16'hfdff;
  assign general_pin_in = ~general_pin_oe & {ext_fault_n, n == RISE, 2'b11};
endmodule
`default_nettype wire

// >>> sim/hsl_props.sv
/* Port assertions for hsl_top.
   Assumes a bind into hsl_top; comparator flags cross two sync flops. */
`timescale 1ns/10ps
`default_nettype none
module hsl_props (
  input wire logic                   ref_clk,
  input wire logic                   rstn,
  input wire logic [hsl_pkg::AW-1:0] reg_addr,
  input wire logic [hsl_pkg::DW-1:0] reg_wdata,
  input wire logic                   reg_wr,
  input wire logic                   vin_uvlo_ok,
  input wire logic                   undervolt_upper_input,
  input wire logic                   undervolt_lower_input,
  input wire logic                   overvolt_input,
  input wire logic                   enable_n,
  input wire logic                   short_trip,
  input wire logic                   write_protect,
  input wire logic                   gate_on,
  input wire logic                   fast_pulldown,
  input wire logic [3:0]             ilim_code,
  input wire logic [2:0]             conv_res,
  input wire logic                   nvm_write,
  input wire logic                   nvm_fault_log
);
  import hsl_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Four samples cover two sync flops plus the gate register
  a_lockout_off: assert property (!vin_uvlo_ok [*4] |-> !gate_on)
    else $error("gate on under supply lockout");
  a_ov_off: assert property (overvolt_input [*4] |-> !gate_on)
    else $error("gate on during overvoltage");
  a_enable_off: assert property (enable_n [*4] |-> !gate_on)
    else $error("gate on while disabled");
  a_uv_off: assert property ((!undervolt_upper_input && !undervolt_lower_input) [*5] |-> !gate_on)
    else $error("gate on below both levels");
  a_short_fast: assert property (short_trip [*4] |-> fast_pulldown)
    else $error("no fast pulldown on short");
  a_rise_cond: assert property ($rose(gate_on) |-> !$past(enable_n, 3)
    && $past(undervolt_upper_input, 3) && $past(undervolt_lower_input, 3))
    else $error("gate rose without start conditions");
  a_ilim_write: assert property (reg_wr && reg_addr == REG_ILIM |=> ilim_code == 4'($past(reg_wdata)))
    else $error("limit setting not taken");
  a_res_clamp: assert property (reg_wr && reg_addr == REG_ADC && reg_wdata[2:0] > RES_MAX |=> conv_res == RES_MAX)
    else $error("resolution not clamped");
  a_wp_block: assert property (write_protect [*4] |-> !nvm_write || nvm_fault_log)
    else $error("memory write while protected");
endmodule
`default_nettype wire

// >>> sim/test_hot_swap_supervisor_logic.sv
/* Self-checking bench for hsl_top with the far side model.
   Assumes short tick (10 cycles) and watchdog timeout of 5 ticks. */
`timescale 1ns/10ps
`default_nettype none
module test_hot_swap_supervisor_logic;
  import hsl_pkg::*;
  logic [AW-1:0] reg_addr;
  logic [DW-1:0] reg_wdata, reg_rdata, current_converter, voltage_converter, rv;
  logic [3:0]    general_pin_in, general_pin_out, general_pin_oe, ilim_code, aux_sel;
  logic [2:0]    conv_res;
  logic [1:0]    foldback_code;
  logic          ref_clk, rstn, reg_wr, reg_rd, vin_uvlo_ok, undervolt_upper_input;
  logic          undervolt_lower_input, overvolt_input, enable_n, short_trip, write_protect;
  logic          ext_fault_n, output_low_threshold, drain_low, gate_high, conv_valid, gate_on;
  logic          fast_pulldown, ramp_inrush, foldback_on, volt_src_drain, energy_alert;
  logic          nvm_write, nvm_fault_log, log_seen, usr_nvm;
  logic          internal_logic_supply_ok = 1'b1, undervolt_lower_reset = 1'b0;
  logic          fet_bad_flag = 1'b0, fet_short_flag = 1'b0, thermal_timer_node = 1'b0;
  int            err_count, total_checks, c;
  hsl_top #(.TICK_CYCLES(10), .PGI_TMO_MS(5)) DUT (.*);
  hsl_partner #(.RISE(6)) u_far (.*);
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (nvm_fault_log === 1'b1) log_seen <= 1'b1;
    if (nvm_write === 1'b1 && nvm_fault_log !== 1'b1) usr_nvm <= 1'b1;
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task give_verdict;
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [AW-1:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  // Sample at falling edges, clear of register updates
  task wt(input int s, input logic v, input int k);
    c = 0;
    while ((s == 0 ? gate_on : general_pin_oe[s-1]) !== v && c < k) begin
      @(negedge ref_clk);
      c++;
    end
    if (c >= k) begin
      chk(16'(c), 16'(k - 1));
      give_verdict();
    end
  endtask
  task pulse_en;
    @(posedge ref_clk) enable_n <= 1'b1;
    cyc(5);
    @(posedge ref_clk) enable_n <= 1'b0;
  endtask
  task t_regs;
    chk(ilim_code, ILIM_RST);
    wr(REG_ILIM, 16'h3);
    cyc(1);
    chk(ilim_code, 16'h3);
    for (int k = 0; k < 4; k++) begin
      wr(REG_FOLD, 16'(k));
      cyc(1);
      chk(foldback_code, 16'(k));
    end
    wr(REG_ADC, 16'h00ff);
    cyc(1);
    chk({aux_sel, 1'b0, conv_res}, {AUX_MAX, 1'b0, RES_MAX});
    wr(REG_CTRL, 16'h0003);
    cyc(1);
    chk(ramp_inrush, 1'b1);
    wr(REG_CTRL, CTRL_RST);
    rd(4'hf);
    chk(rv, 16'h0000);
    rd(REG_POWER);
    chk(rv, 16'h0002);
    @(posedge ref_clk) write_protect <= 1'b1;
    cyc(4);
    wr(REG_NVM, 16'h0001);
    cyc(3);
    chk(usr_nvm, 1'b0);
    @(posedge ref_clk) write_protect <= 1'b0;
    cyc(4);
    wr(REG_NVM, 16'h0001);
    cyc(3);
    chk(usr_nvm, 1'b1);
    $display("regs done");
  endtask
  task t_start;
    @(posedge ref_clk) enable_n <= 1'b0;
    cyc(600);
    chk(gate_on, 1'b0);
    pulse_en();
    wt(0, 1'b1, 2000);
    chk(c >= 1270 && c <= 1300, 1'b1);
    wt(1, 1'b0, 3000);
    chk(c >= 2540 && c <= 2600, 1'b1);
    wt(2, 1'b0, 3000);
    chk(c >= 2540 && c <= 2600, 1'b1);
    cyc(100);
    chk(gate_on, 1'b1);
    $display("start done");
  endtask
  task t_ov;
    @(posedge ref_clk) overvolt_input <= 1'b1;
    cyc(4);
    chk(gate_on, 1'b0);
    chk(general_pin_oe[1:0], 2'b00);
    @(posedge ref_clk) overvolt_input <= 1'b0;
    rd(REG_FAULT);
    chk(rv[F_OV], 1'b1);
    chk(log_seen, 1'b1);
    wr(REG_FAULT, 16'h0001);
    rd(REG_FAULT);
    chk(rv[F_OV], 1'b0);
    wt(0, 1'b1, 1400);
    $display("ov done");
  endtask
  task t_hyst;
    @(posedge ref_clk) undervolt_upper_input <= 1'b0;
    cyc(20);
    chk(gate_on, 1'b1);
    @(posedge ref_clk) undervolt_lower_input <= 1'b0;
    cyc(4);
    chk(gate_on, 1'b0);
    rd(REG_FAULT);
    chk(rv[F_UV], 1'b1);
    @(posedge ref_clk) undervolt_lower_reset <= 1'b1;
    cyc(3);
    @(posedge ref_clk) undervolt_lower_reset <= 1'b0;
    rd(REG_FAULT);
    chk(rv[F_UV], 1'b0);
    @(posedge ref_clk) undervolt_lower_input <= 1'b1;
    cyc(1400);
    chk(gate_on, 1'b0);
    @(posedge ref_clk) undervolt_upper_input <= 1'b1;
    wt(0, 1'b1, 1400);
    $display("hyst done");
  endtask
  task t_short;
    @(posedge ref_clk) short_trip <= 1'b1;
    cyc(4);
    chk(fast_pulldown, 1'b1);
    @(posedge ref_clk) short_trip <= 1'b0;
    cyc(1400);
    chk(gate_on, 1'b0);
    pulse_en();
    wt(0, 1'b1, 1400);
    @(posedge ref_clk) vin_uvlo_ok <= 1'b0;
    cyc(4);
    chk(gate_on, 1'b0);
    $display("short done");
  endtask
  initial begin
    {reg_wr, reg_rd, overvolt_input, short_trip, write_protect, log_seen, usr_nvm} = '0;
    {vin_uvlo_ok, undervolt_upper_input, undervolt_lower_input, enable_n, ext_fault_n} = '1;
    reg_addr = '0;
    reg_wdata = '0;
    err_count = 0;
    total_checks = 0;
    rstn = 1'b0;
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    t_regs();
    t_start();
    t_ov();
    t_hyst();
    t_short();
    give_verdict();
  end
endmodule
bind hsl_top hsl_props u_props (.*);
`default_nettype wire
